// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam logic [11:0] SET = wdh_pkg::SETUP_ADDR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        external_reset_pin_n = 1'b1;
  logic [7:0]  port_a_pins = 8'hFF;
  logic [7:0]  port_a_wake_mask = 8'h08;
  logic        int_request = 1'b0;
  logic        int_enabled = 1'b1;
  logic        stack_full = 1'b0;
  logic        dual_clear = 1'b0;
  logic        rc_osc_tick, watchdog_clear_instr, watchdog_clear_first_instr;
  logic        watchdog_clear_second_instr, halt_instr, sys_clk_en, chip_reset_req;
  logic        warm_reset_req, timeout_flag, power_down_flag, halted, dummy_active;
  logic        resume_next, resume_interrupt;
  // Event index: 2 chip reset, 3 warm reset, 4 resume, 5 interrupt resume
  wire logic [5:0] ev = {resume_interrupt, resume_next, warm_reset_req, chip_reset_req,
                         dummy_active, halted};
  int          num_errors = 0;
  int          n_checks = 0;
  always #20 aclk = ~aclk;
  wdh_watchdog u_wdh_watchdog (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_reset_pin_n, .rc_osc_tick,
    .watchdog_clear_instr, .watchdog_clear_first_instr, .watchdog_clear_second_instr,
    .halt_instr, .port_a_pins, .port_a_wake_mask, .int_request, .int_enabled,
    .stack_full, .sys_clk_en, .chip_reset_req, .warm_reset_req, .timeout_flag,
    .power_down_flag, .halted, .dummy_active, .resume_next, .resume_interrupt
  );
  wdh_core_model u_wdh_core_model (
    .aclk, .dual_clear, .watchdog_clear_instr, .watchdog_clear_first_instr,
    .watchdog_clear_second_instr, .halt_instr, .rc_osc_tick
  );
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Bounded wait; a missing event that must come ends the run
  task automatic wait_ev(input int i, input int lim, input bit must, output int n);
    for (n = 0; n < lim && ev[i] !== 1'b1; n++)
      @(negedge aclk);
    if (must && n == lim)
    begin
      check("event_seen", i, 32'hFF);
      conclude();
    end
  endtask : wait_ev
  // Handshakes judged at the negedge, which shows what the next rising edge samples
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] exp);
    bit aw, w, done;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int k = 0; k < 50 && !done; k++)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    check("bresp", done ? r : 2'h3, exp);
    if (!done) conclude();
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar, done;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int k = 0; k < 50 && !done; k++)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    check("rvalid", done, 1'b1);
    if (!done) conclude();
  endtask : axi_rd
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(what, d, exp);
  endtask : rd_chk
  task automatic set_cfg(input logic [7:0] cfg, input logic [2:0] ws);
    dual_clear = cfg[3];
    axi_wr(wdh_pkg::CONFIG_ADDR, cfg, wdh_pkg::AXI_OKAY);
    axi_wr(SET, {5'h10, ws}, wdh_pkg::AXI_OKAY);
  endtask : set_cfg
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd_chk("setup_rst", SET, 32'h0000_0087);
    rd_chk("config_rst", wdh_pkg::CONFIG_ADDR, 32'h0000_0007);
    rd_chk("status_rst", wdh_pkg::STATUS_ADDR, 32'h0000_0000);
    axi_rd(12'h0F0, d, r);
    check("rd_unmapped", r, wdh_pkg::AXI_SLVERR);
    axi_wr(12'h0F0, 8'hFF, wdh_pkg::AXI_SLVERR);
    axi_wr(SET, 8'h7B, wdh_pkg::AXI_OKAY);
    rd_chk("user_keep", SET, 32'h0000_0083);
  endtask : t_regs
  // Instruction clock is aclk/8; a tick count of 2^(8+ws) sets the timeout
  task automatic t_timeout(input logic [7:0] cfg, input logic [2:0] ws, input int exp);
    int n;
    set_cfg(cfg, ws);
    u_wdh_core_model.clear_wdt();
    wait_ev(2, exp + 64, 1, n);
    check("to_time", n > exp - 40 && n < exp + 40, 1'b1);
    check("to_flag", timeout_flag, 1'b1);
    wait_ev(4, 2200, 1, n);
    rd_chk("setup_restore", SET, 32'h0000_0087);
  endtask : t_timeout
  task automatic t_clear();
    int n;
    set_cfg(8'h01, 3'h0);
    u_wdh_core_model.clear_wdt();
    check("to_cleared", timeout_flag, 1'b0);
    cyc(1500);
    u_wdh_core_model.clear_wdt();
    wait_ev(2, 1800, 0, n);
    check("clr_hold", n, 1800);
    wait_ev(2, 400, 1, n);
    wait_ev(4, 2200, 1, n);
  endtask : t_clear
  task automatic t_dual();
    int n;
    set_cfg(8'h09, 3'h0);
    u_wdh_core_model.clear_wdt();
    cyc(1000);
    u_wdh_core_model.clear_wdt();
    wait_ev(2, 1800, 0, n);
    check("dual_both", n, 1800);
    u_wdh_core_model.kick(2'h1);
    wait_ev(2, 400, 1, n);
    wait_ev(4, 2200, 1, n);
  endtask : t_dual
  task automatic t_halt_rc();
    int n;
    set_cfg(8'h07, 3'h0);
    u_wdh_core_model.kick(2'h3);
    cyc(2);
    check("halt_flags", {timeout_flag, power_down_flag}, 2'h1);
    wait_ev(3, 4200, 1, n);
    check("warm_time", n > 4050 && n < 4140, 1'b1);
    cyc(2);
    check("warm_flags", {timeout_flag, power_down_flag}, 2'h3);
    wait_ev(4, 2200, 1, n);
    rd_chk("warm_setup", SET, 32'h0000_0080);
  endtask : t_halt_rc
  task automatic t_halt_port();
    int n;
    set_cfg(8'h01, 3'h0);
    u_wdh_core_model.kick(2'h3);
    cyc(2);
    check("halt_to", {halted, timeout_flag}, 2'h2);
    wait_ev(3, 3000, 0, n);
    check("no_warm", n, 3000);
    check("clk_stop", sys_clk_en, 1'b0);
    port_a_pins <= 8'hFE;
    cyc(20);
    check("mask_off", halted, 1'b1);
    port_a_pins <= 8'hF6;
    wait_ev(4, 2200, 1, n);
    check("dummy_time", n > 2040 && n < 2070, 1'b1);
    wait_ev(5, 4, 0, n);
    check("no_int_resume", n, 4);
    check("pdf_keep", power_down_flag, 1'b1);
    port_a_pins <= 8'hFF;
    u_wdh_core_model.clear_wdt();
    check("pdf_clear", power_down_flag, 1'b0);
  endtask : t_halt_port
  task automatic t_disabled();
    int n;
    set_cfg(8'h00, 3'h0);
    u_wdh_core_model.clear_wdt();
    wait_ev(2, 5000, 0, n);
    check("wdt_off", n, 5000);
  endtask : t_disabled
  task automatic t_int(input logic full);
    int n;
    set_cfg(8'h01, 3'h0);
    stack_full <= full;
    int_request <= 1'b1;
    u_wdh_core_model.kick(2'h3);
    cyc(100);
    check("pend_nowake", halted, 1'b1);
    int_request <= 1'b0;
    cyc(5);
    int_request <= 1'b1;
    wait_ev(4, 2300, 1, n);
    @(negedge aclk);
    check("int_resume", resume_interrupt, !full);
    int_request <= 1'b0;
  endtask : t_int
  task automatic t_pin();
    int n;
    set_cfg(8'h01, 3'h0);
    u_wdh_core_model.kick(2'h3);
    cyc(5);
    external_reset_pin_n <= 1'b0;
    cyc(2);
    external_reset_pin_n <= 1'b1;
    wait_ev(4, 2300, 1, n);
    check("pin_flags", {timeout_flag, power_down_flag}, 2'h0);
    rd_chk("pin_setup", SET, 32'h0000_0087);
  endtask : t_pin
  initial
  begin
    cyc(10);
    aresetn <= 1'b1;
    t_regs();
    for (int w = 0; w < 3; w++)
      t_timeout(8'h01, w[2:0], 2048 << w);
    t_timeout(8'h07, 3'h0, 4096);
    t_clear();
    t_dual();
    t_halt_rc();
    t_halt_port();
    t_disabled();
    t_int(1'b0);
    t_int(1'b1);
    t_pin();
    conclude();
  end
endmodule : testbench

// ---- dv/wdh_core_model.sv ----
`timescale 1ns/1ps
module wdh_core_model (
  input  wire logic aclk,
  input  wire logic dual_clear,
  output logic      watchdog_clear_instr,
  output logic      watchdog_clear_first_instr,
  output logic      watchdog_clear_second_instr,
  output logic      halt_instr,
  output logic      rc_osc_tick
);
  logic [3:0] rc_phase = 4'h0;
  // Free running, also through halt; one period per 16 aclk
  always @(posedge aclk)
    rc_phase <= rc_phase + 4'h1;
  assign rc_osc_tick = rc_phase[3];
  initial
    {watchdog_clear_instr, watchdog_clear_first_instr, watchdog_clear_second_instr,
     halt_instr} = 4'h0;
  task automatic kick(input logic [1:0] op);
    @(posedge aclk);
    case (op)
      2'h0: watchdog_clear_instr <= 1'b1;
      2'h1: watchdog_clear_first_instr <= 1'b1;
      2'h2: watchdog_clear_second_instr <= 1'b1;
      default: halt_instr <= 1'b1;
    endcase
    @(posedge aclk);
    {watchdog_clear_instr, watchdog_clear_first_instr, watchdog_clear_second_instr,
     halt_instr} <= 4'h0;
    @(negedge aclk);
  endtask : kick
  task automatic clear_wdt();
    if (dual_clear)
    begin
      kick(2'h1);
      kick(2'h2);
    end
    else
      kick(2'h0);
  endtask : clear_wdt
endmodule : wdh_core_model

// ---- dv/wdh_watchdog_asserts.sv ----
`timescale 1ns/1ps
module wdh_watchdog_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        external_reset_pin_n,
  input wire logic [7:0]  port_a_pins,
  input wire logic [7:0]  port_a_wake_mask,
  input wire logic        sys_clk_en,
  input wire logic        chip_reset_req,
  input wire logic        warm_reset_req,
  input wire logic        timeout_flag,
  input wire logic        power_down_flag,
  input wire logic        halted,
  input wire logic        dummy_active,
  input wire logic        resume_next,
  input wire logic        resume_interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] dummy_cnt;
  always_ff @(posedge aclk)
    dummy_cnt <= (!aresetn || !dummy_active) ? 12'h000 : dummy_cnt + 12'h001;
  chk_sysclk_toggle: assert property ((!halted && !dummy_active && external_reset_pin_n) [*3]
    |-> sys_clk_en != $past(sys_clk_en)) else $error("system clock not halved");
  chk_sysclk_halt: assert property (halted [*2] |-> !sys_clk_en)
    else $error("system clock runs in halt");
  chk_chip_timeout: assert property (chip_reset_req |-> ##[0:1] timeout_flag)
    else $error("chip reset without timeout flag");
  chk_chip_running: assert property (chip_reset_req |-> !$past(halted))
    else $error("chip reset from halt");
  chk_warm_halted: assert property (warm_reset_req |-> $past(halted))
    else $error("warm reset outside halt");
  chk_halt_flags: assert property ($rose(halted) |-> ##[0:1] (power_down_flag && !timeout_flag))
    else $error("halt flags wrong");
  chk_port_wake: assert property (halted && |(port_a_wake_mask & $past(port_a_pins) & ~port_a_pins)
    |-> ##[1:6] !halted) else $error("port fall did not wake");
  chk_dummy_len: assert property ($fell(dummy_active) |-> dummy_cnt inside {[12'h800:12'h803]})
    else $error("dummy period length wrong");
  chk_resume_after: assert property (resume_next |-> $past(dummy_active))
    else $error("resume without dummy period");
  chk_int_follow: assert property (resume_interrupt |-> $past(resume_next))
    else $error("interrupt resume out of order");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  cov_chip: cover property (chip_reset_req);
  cov_warm: cover property (warm_reset_req);
  cov_int: cover property (resume_interrupt);
endmodule : wdh_watchdog_asserts
bind wdh_watchdog wdh_watchdog_asserts u_wdh_watchdog_asserts (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .external_reset_pin_n, .port_a_pins, .port_a_wake_mask, .sys_clk_en,
  .chip_reset_req, .warm_reset_req, .timeout_flag, .power_down_flag, .halted,
  .dummy_active, .resume_next, .resume_interrupt
);

// ---- verilog/wdh_pkg.sv ----
package wdh_pkg;
  // Register map, byte addresses over AXI4-Lite (index times four)
  localparam int unsigned    SETUP_INDEX      = 32'h0000_0009;
  localparam logic [11:0]    SETUP_ADDR       = 12'h024;
  localparam logic [11:0]    CONFIG_ADDR      = 12'h040;
  localparam logic [11:0]    STATUS_ADDR      = 12'h044;
  // Setup register fields and reset value
  localparam int unsigned    PRESCALE_LSB     = 0;
  localparam int unsigned    PRESCALE_MSB     = 2;
  localparam int unsigned    USER_LSB         = 3;
  localparam int unsigned    USER_MSB         = 7;
  localparam logic [4:0]     USER_PATTERN     = 5'h10;
  localparam logic [7:0]     SETUP_RESET      = 8'h87;
  // Configuration register bits
  localparam int unsigned    CFG_WDT_ENABLE   = 0;
  localparam int unsigned    CFG_RC_SELECT    = 1;
  localparam int unsigned    CFG_RC_ENABLE    = 2;
  localparam int unsigned    CFG_DUAL_CLEAR   = 3;
  localparam logic [3:0]     CONFIG_RESET     = 4'h7;
  // Status register bits
  localparam int unsigned    STS_TIMEOUT      = 0;
  localparam int unsigned    STS_POWER_DOWN   = 1;
  localparam int unsigned    STS_HALTED       = 2;
  localparam int unsigned    STS_DUMMY        = 3;
  // Clock figures, AXI response codes and state encoding
  localparam int unsigned    INSTR_DIVIDE     = 4;
  localparam int unsigned    FIXED_STAGES     = 8;
  localparam int unsigned    DUMMY_PERIODS    = 1024;
  localparam int unsigned    SYSCLK_DIVIDE    = 2;
  localparam logic [1:0]     AXI_OKAY         = 2'h0;
  localparam logic [1:0]     AXI_SLVERR       = 2'h2;
  typedef enum logic [1:0] {WDH_RUN, WDH_HALT, WDH_DUMMY} wdh_state_t;
endpackage : wdh_pkg

// ---- verilog/wdh_watchdog.sv ----
// How it works
// - System clock enable is the crystal rate halved.
// - Halt stops the system clock; external clock ignored.
// - Option picks RC oscillator or instruction clock (system clock / 4).
// - Watchdog disabled: clear, halt clearing and timeouts do nothing.
// - Selected clock first passes a fixed divide-by-256 stage.
// - Setup bits 2:0 add division two to the field power.
// - Setup bits 7:3 are user flags, writable only as 10000.
// - Instruction-clocked watchdog stops counting in halt.
// - Overflow when running requests chip reset and sets timeout flag.
// - Overflow in halt requests warm reset of PC and stack pointer.
// - Reset pin low, clear instructions or halt clear counter and prescaler.
// - Option picks single clear or both distinct clear instructions.
// - Halt keeps RC oscillator running; other state untouched.
// - Halt entry with RC clock clears then restarts the watchdog.
// - Halt sets power-down flag and clears timeout flag.
// - Power-down flag cleared only by power-up, reset pin low or clear instruction.
// - Halt left by reset pin, interrupt, port A fall or overflow.
// - Per-bit mask enables port A wake; resumes next instruction.
// - Interrupt wake resumes next if disabled or stack full.
// - Interrupt pending at halt entry cannot wake.
// - Every wake inserts 1024 system clock dummy periods.
// - Next instruction right after dummy; interrupt service one cycle later.
// - Timeout flag cleared by power-up, clear, halt; set only by timeout.
// - Start-up delay of 1024 system clocks on resets and wakes; power-up via aresetn goes straight to run.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module wdh_watchdog (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core side
  input  wire logic        external_reset_pin_n,
  input  wire logic        rc_osc_tick,
  input  wire logic        watchdog_clear_instr,
  input  wire logic        watchdog_clear_first_instr,
  input  wire logic        watchdog_clear_second_instr,
  input  wire logic        halt_instr,
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_a_wake_mask,
  input  wire logic        int_request,
  input  wire logic        int_enabled,
  input  wire logic        stack_full,
  output logic             sys_clk_en,
  output logic             chip_reset_req,
  output logic             warm_reset_req,
  output logic             timeout_flag,
  output logic             power_down_flag,
  output logic             halted,
  output logic             dummy_active,
  output logic             resume_next,
  output logic             resume_interrupt
);

  logic [7:0]              watchdog_setup;
  logic [3:0]              wdt_config;
  logic                    aw_held;
  logic                    w_held;
  logic [11:0]             aw_addr;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  wdh_pkg::wdh_state_t     state;
  logic                    xtal_phase;
  logic [1:0]              instr_div;
  logic                    rc_sync1;
  logic                    rc_sync2;
  logic                    rc_last;
  logic [15:0]             wdt_count;
  logic                    first_seen;
  logic                    second_seen;
  logic [10:0]             dummy_count;
  logic                    wake_by_int;
  logic                    int_blocked;
  logic [7:0]              port_a_last;
  logic                    wdt_enable;
  logic                    rc_select;
  logic                    wdt_tick;
  logic                    wdt_clear;
  logic                    sw_clear;
  logic                    overflow;
  logic [3:0]              stage;
  logic                    port_wake;
  logic                    int_wake;
  logic                    halt_go;
  logic                    write_fire;

  assign wdt_enable = wdt_config[wdh_pkg::CFG_WDT_ENABLE];
  assign rc_select  = wdt_config[wdh_pkg::CFG_RC_SELECT] & wdt_config[wdh_pkg::CFG_RC_ENABLE];

  // AXI4-Lite: address and data latched in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign write_fire    = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (write_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (write_fire)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= wdh_pkg::AXI_OKAY;
    end
    else if (write_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[11:2] == wdh_pkg::SETUP_ADDR[11:2] ||
                       aw_addr[11:2] == wdh_pkg::CONFIG_ADDR[11:2] ||
                       aw_addr[11:2] == wdh_pkg::STATUS_ADDR[11:2])
                      ? wdh_pkg::AXI_OKAY : wdh_pkg::AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Register writes; chip reset restores setup, config only by aresetn
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      watchdog_setup <= wdh_pkg::SETUP_RESET;
      wdt_config     <= wdh_pkg::CONFIG_RESET;
    end
    else if (!external_reset_pin_n || chip_reset_req)
      watchdog_setup <= wdh_pkg::SETUP_RESET;
    else if (write_fire && w_strb[0])
    begin
      if (aw_addr[11:2] == wdh_pkg::SETUP_ADDR[11:2])
      begin
        watchdog_setup[wdh_pkg::PRESCALE_MSB:wdh_pkg::PRESCALE_LSB] <= w_data[2:0];
        if (w_data[7:3] == wdh_pkg::USER_PATTERN)
          watchdog_setup[wdh_pkg::USER_MSB:wdh_pkg::USER_LSB] <= w_data[7:3];
      end
      else if (aw_addr[11:2] == wdh_pkg::CONFIG_ADDR[11:2])
        wdt_config <= w_data[3:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= wdh_pkg::AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= wdh_pkg::AXI_OKAY;
      if (s_axi_araddr[11:2] == wdh_pkg::SETUP_ADDR[11:2])
        s_axi_rdata <= {24'h00_0000, watchdog_setup};
      else if (s_axi_araddr[11:2] == wdh_pkg::CONFIG_ADDR[11:2])
        s_axi_rdata <= {28'h000_0000, wdt_config};
      else if (s_axi_araddr[11:2] == wdh_pkg::STATUS_ADDR[11:2])
        s_axi_rdata <= {28'h000_0000, dummy_active, halted, power_down_flag, timeout_flag};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= wdh_pkg::AXI_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Crystal-rate aclk halved; stopped in halt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xtal_phase <= 1'b0;
    else if (state == wdh_pkg::WDH_HALT)
      xtal_phase <= 1'b0;
    else
      xtal_phase <= ~xtal_phase;
  end
  assign sys_clk_en = xtal_phase;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      instr_div <= 2'h0;
    else if (sys_clk_en)
      instr_div <= instr_div + 2'h1;
  end

  // RC tick: first flop feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_sync1 <= 1'b0;
      rc_sync2 <= 1'b0;
      rc_last  <= 1'b0;
    end
    else
    begin
      rc_sync1 <= rc_osc_tick;
      rc_sync2 <= rc_sync1;
      rc_last  <= rc_sync2;
    end
  end

  always_comb
  begin
    if (rc_select)
      wdt_tick = rc_sync2 && !rc_last;
    else
      wdt_tick = sys_clk_en && (instr_div == 2'h3);
  end

  // Dual clear needs both distinct instructions, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !wdt_config[wdh_pkg::CFG_DUAL_CLEAR] || sw_clear)
    begin
      first_seen  <= 1'b0;
      second_seen <= 1'b0;
    end
    else
    begin
      if (watchdog_clear_first_instr)
        first_seen <= 1'b1;
      if (watchdog_clear_second_instr)
        second_seen <= 1'b1;
    end
  end

  always_comb
  begin
    if (wdt_config[wdh_pkg::CFG_DUAL_CLEAR])
      sw_clear = (first_seen || watchdog_clear_first_instr) &&
                 (second_seen || watchdog_clear_second_instr);
    else
      sw_clear = watchdog_clear_instr;
  end

  assign halt_go   = halt_instr && state == wdh_pkg::WDH_RUN;
  assign wdt_clear = !external_reset_pin_n || sw_clear || halt_go;

  // Fixed 8 stages then 0..7 prescaler stages
  assign stage    = 4'(wdh_pkg::FIXED_STAGES) + {1'b0, watchdog_setup[2:0]};
  // Carry out after 2^stage ticks; count is zero above the stage
  assign overflow = wdt_enable && wdt_tick &&
                    ((wdt_count & ((16'h0001 << stage) - 16'h0001)) ==
                     ((16'h0001 << stage) - 16'h0001));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || wdt_clear || !wdt_enable || overflow)
      wdt_count <= 16'h0000;
    else if (wdt_tick)
      wdt_count <= wdt_count + 16'h0001;
  end

  // Halt, wake and dummy period sequencing
  assign port_wake = |(port_a_last & ~port_a_pins & port_a_wake_mask);
  assign int_wake  = int_request && !int_blocked;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      port_a_last <= 8'hFF;
    else
      port_a_last <= port_a_pins;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state       <= wdh_pkg::WDH_RUN;
      dummy_count <= 11'h000;
      wake_by_int <= 1'b0;
      int_blocked <= 1'b0;
    end
    else if (!external_reset_pin_n)
    begin
      state       <= wdh_pkg::WDH_DUMMY;
      dummy_count <= 11'h000;
      wake_by_int <= 1'b0;
    end
    else
    begin
      case (state)
        wdh_pkg::WDH_RUN:
          if (overflow)
          begin
            state       <= wdh_pkg::WDH_DUMMY;
            dummy_count <= 11'h000;
            wake_by_int <= 1'b0;
          end
          else if (halt_instr)
          begin
            state       <= wdh_pkg::WDH_HALT;
            int_blocked <= int_request;
          end
        wdh_pkg::WDH_HALT:
          if (overflow || port_wake || int_wake)
          begin
            state       <= wdh_pkg::WDH_DUMMY;
            dummy_count <= 11'h000;
            wake_by_int <= int_wake && !overflow && int_enabled && !stack_full;
          end
          else if (!int_request)
            int_blocked <= 1'b0;
        wdh_pkg::WDH_DUMMY:
          if (dummy_count == 11'(wdh_pkg::DUMMY_PERIODS * wdh_pkg::SYSCLK_DIVIDE - 1))
            state <= wdh_pkg::WDH_RUN;
          else
            dummy_count <= dummy_count + 11'h001;
        default:
          state <= wdh_pkg::WDH_RUN;
      endcase
    end
  end

  assign halted       = state == wdh_pkg::WDH_HALT;
  assign dummy_active = state == wdh_pkg::WDH_DUMMY;

  // One-cycle resume strobes; interrupt path waits one more cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      resume_next      <= 1'b0;
      resume_interrupt <= 1'b0;
    end
    else
    begin
      resume_next      <= dummy_active && !wake_by_int &&
                          dummy_count == 11'(wdh_pkg::DUMMY_PERIODS * wdh_pkg::SYSCLK_DIVIDE - 1)
                          && external_reset_pin_n;
      resume_interrupt <= resume_next && wake_by_int;
      if (dummy_active && wake_by_int && external_reset_pin_n &&
          dummy_count == 11'(wdh_pkg::DUMMY_PERIODS * wdh_pkg::SYSCLK_DIVIDE - 1))
        resume_next <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chip_reset_req <= 1'b0;
      warm_reset_req <= 1'b0;
    end
    else
    begin
      chip_reset_req <= overflow && state == wdh_pkg::WDH_RUN;
      warm_reset_req <= overflow && state == wdh_pkg::WDH_HALT;
    end
  end

  // Timeout set wins over any clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timeout_flag <= 1'b0;
    else if (overflow)
      timeout_flag <= 1'b1;
    else if (!external_reset_pin_n || (wdt_enable && (sw_clear || halt_go)))
      timeout_flag <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_down_flag <= 1'b0;
    else if (halt_go)
      power_down_flag <= 1'b1;
    else if (!external_reset_pin_n || (wdt_enable && sw_clear))
      power_down_flag <= 1'b0;
  end

endmodule : wdh_watchdog
